// ==== hdl/iofo_top.sv ====
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps

module iofo_top
    import iofo_pkg::*;
#(
    parameter int PO_W = IOFO_PO_W,
    parameter int LI_W = IOFO_LI_W
) (
    input wire logic mclk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IOFO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Ordinary sources
    input wire logic [PO_W-1:0] phys_out_normal,
    input wire logic [LI_W-1:0] logic_in_normal,
    // Effective values
    output logic [PO_W-1:0] phys_out,
    output logic [LI_W-1:0] logic_in,
    output logic phys_trip_out,
    output logic phys_output_one,
    output logic phys_output_six,
    output logic forced_logic_input_first,
    output logic forced_logic_input_last,
    output logic override_active
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    localparam logic [IOFO_ADDR_W-1:0] A_PO_EN =
        IOFO_ADDR_W'({IOFO_IDX_PO_ENABLE, 2'b00});
    localparam logic [IOFO_ADDR_W-1:0] A_PO_LV =
        IOFO_ADDR_W'({IOFO_IDX_PO_LEVEL, 2'b00});
    localparam logic [IOFO_ADDR_W-1:0] A_LI_EN =
        IOFO_ADDR_W'({IOFO_IDX_LI_ENABLE, 2'b00});
    localparam logic [IOFO_ADDR_W-1:0] A_LI_LV =
        IOFO_ADDR_W'({IOFO_IDX_LI_LEVEL, 2'b00});
    localparam logic [IOFO_ADDR_W-1:0] A_PO_ST =
        IOFO_ADDR_W'({IOFO_IDX_PO_STATUS, 2'b00});
    localparam logic [IOFO_ADDR_W-1:0] A_LI_ST =
        IOFO_ADDR_W'({IOFO_IDX_LI_STATUS, 2'b00});
    localparam logic [IOFO_ADDR_W-1:0] A_SUM =
        IOFO_ADDR_W'({IOFO_IDX_SUMMARY, 2'b00});

    logic setup;
    logic access;
    logic sel_po_en;
    logic sel_po_lv;
    logic sel_li_en;
    logic sel_li_lv;
    logic sel_po_st;
    logic sel_li_st;
    logic sel_sum;
    logic mapped;
    logic writable;

    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        sel_po_en = (paddr == A_PO_EN);
        sel_po_lv = (paddr == A_PO_LV);
        sel_li_en = (paddr == A_LI_EN);
        sel_li_lv = (paddr == A_LI_LV);
        sel_po_st = (paddr == A_PO_ST);
        sel_li_st = (paddr == A_LI_ST);
        sel_sum = (paddr == A_SUM);
        writable = sel_po_en || sel_po_lv || sel_li_en || sel_li_lv;
        mapped = writable || sel_po_st || sel_li_st || sel_sum;
    end

    // Zero wait states: read data is captured in the setup cycle
    always_comb begin
        pready = access;
    end

    // ------------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------------
    function automatic logic [31:0] iofo_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction : iofo_merge

    // ------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------
    logic [PO_W-1:0] po_enable_q;
    logic [PO_W-1:0] po_enable_d;
    logic [PO_W-1:0] po_level_q;
    logic [PO_W-1:0] po_level_d;
    logic [LI_W-1:0] li_enable_q;
    logic [LI_W-1:0] li_enable_d;
    logic [LI_W-1:0] li_level_q;
    logic [LI_W-1:0] li_level_d;
    logic wr_fire;

    always_comb begin
        wr_fire = access && pwrite && pready;
        po_enable_d = po_enable_q;
        po_level_d = po_level_q;
        li_enable_d = li_enable_q;
        li_level_d = li_level_q;
        if (wr_fire && sel_po_en) begin
            po_enable_d = PO_W'(iofo_merge(32'(po_enable_q), pwdata, pstrb))
                          & PO_W'(IOFO_PO_WMASK);
        end
        if (wr_fire && sel_po_lv) begin
            po_level_d = PO_W'(iofo_merge(32'(po_level_q), pwdata, pstrb))
                         & PO_W'(IOFO_PO_WMASK);
        end
        if (wr_fire && sel_li_en) begin
            li_enable_d = LI_W'(iofo_merge(32'(li_enable_q), pwdata,
                                           pstrb));
        end
        if (wr_fire && sel_li_lv) begin
            li_level_d = LI_W'(iofo_merge(32'(li_level_q), pwdata,
                                          pstrb));
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            po_enable_q <= PO_W'(IOFO_PO_RESET);
            po_level_q <= PO_W'(IOFO_PO_RESET);
            li_enable_q <= LI_W'(IOFO_LI_RESET);
            li_level_q <= LI_W'(IOFO_LI_RESET);
        end else begin
            po_enable_q <= po_enable_d;
            po_level_q <= po_level_d;
            li_enable_q <= li_enable_d;
            li_level_q <= li_level_d;
        end
    end

    // ------------------------------------------------------------------
    // Override muxes
    // ------------------------------------------------------------------
    // Physical outputs: 1 in level word asserts, 0 de-asserts
    iofo_force_mux #(
        .WIDTH(PO_W)
    ) u_po_mux (
        .mclk(mclk),
        .resetn(resetn),
        .normal_value(phys_out_normal),
        .override_enable(po_enable_q),
        .forced_level(po_level_q),
        .effective_q(phys_out)
    );

    // Logical inputs: 1 reads set or closed, 0 reset or open
    iofo_force_mux #(
        .WIDTH(LI_W)
    ) u_li_mux (
        .mclk(mclk),
        .resetn(resetn),
        .normal_value(logic_in_normal),
        .override_enable(li_enable_q),
        .forced_level(li_level_q),
        .effective_q(logic_in)
    );

    // ------------------------------------------------------------------
    // Named taps
    // ------------------------------------------------------------------
    always_comb begin
        phys_trip_out = phys_out[IOFO_PO_TRIP_BIT];
        phys_output_one = phys_out[IOFO_PO_OUT_FIRST_BIT];
        phys_output_six = phys_out[IOFO_PO_OUT_LAST_BIT];
        forced_logic_input_first = logic_in[0];
        forced_logic_input_last = logic_in[LI_W-1];
    end

    // ------------------------------------------------------------------
    // Summary flags
    // ------------------------------------------------------------------
    logic po_any_q;
    logic po_any_d;
    logic li_any_q;
    logic li_any_d;

    always_comb begin
        po_any_d = |po_enable_q;
        li_any_d = |li_enable_q;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            po_any_q <= 1'b0;
            li_any_q <= 1'b0;
        end else begin
            po_any_q <= po_any_d;
            li_any_q <= li_any_d;
        end
    end

    always_comb begin
        override_active = po_any_q || li_any_q;
    end

    // ------------------------------------------------------------------
    // Read data and error response
    // ------------------------------------------------------------------
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            // Unmapped access, or a write to a status or summary word, errors
            pslverr_d = !mapped || (pwrite && !writable);
            if (!pwrite) begin
                unique case (1'b1)
                    sel_po_en: prdata_d = 32'(po_enable_q);
                    sel_po_lv: prdata_d = 32'(po_level_q);
                    sel_li_en: prdata_d = 32'(li_enable_q);
                    sel_li_lv: prdata_d = 32'(li_level_q);
                    sel_po_st: prdata_d = 32'(phys_out);
                    sel_li_st: prdata_d = 32'(logic_in);
                    sel_sum: begin
                        prdata_d[IOFO_SUM_PO_ANY_BIT] = po_any_q;
                        prdata_d[IOFO_SUM_LI_ANY_BIT] = li_any_q;
                    end
                    default: prdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    always_comb begin
        prdata = prdata_q;
        pslverr = pslverr_q && access;
    end

endmodule : iofo_top

// ==== hdl/iofo_pkg.sv ====
package iofo_pkg;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IOFO_IDX_PO_ENABLE = 8'h28;
    localparam logic [7:0] IOFO_IDX_PO_LEVEL = 8'h2a;
    localparam logic [7:0] IOFO_IDX_LI_ENABLE = 8'h2c;
    localparam logic [7:0] IOFO_IDX_LI_LEVEL = 8'h30;
    localparam logic [7:0] IOFO_IDX_PO_STATUS = 8'h60;
    localparam logic [7:0] IOFO_IDX_LI_STATUS = 8'h64;
    localparam logic [7:0] IOFO_IDX_SUMMARY = 8'h68;

    localparam int IOFO_ADDR_W = 12;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int IOFO_PO_W = 16;
    localparam int IOFO_LI_W = 32;
    localparam int IOFO_PO_TRIP_BIT = 0;
    localparam int IOFO_PO_CLOSE_BIT = 1;
    localparam int IOFO_PO_OUT_FIRST_BIT = 2;
    localparam int IOFO_PO_OUT_LAST_BIT = 7;
    localparam int IOFO_PO_RSVD_LO_BIT = 8;
    localparam int IOFO_PO_RSVD_HI_BIT = 9;
    localparam int IOFO_PO_SPARE_FIRST_BIT = 10;
    localparam int IOFO_PO_SPARE_LAST_BIT = 15;
    localparam int IOFO_SUM_PO_ANY_BIT = 0;
    localparam int IOFO_SUM_LI_ANY_BIT = 1;

    // Reserved bits 8 and 9 hold no enable or level state and read zero in those words
    localparam logic [15:0] IOFO_PO_WMASK = 16'hfcff;

    // ------------------------------------------------------------------
    // Values after reset: nothing forced
    // ------------------------------------------------------------------
    localparam logic [15:0] IOFO_PO_RESET = 16'h0000;
    localparam logic [31:0] IOFO_LI_RESET = 32'h0000_0000;

endpackage : iofo_pkg

// ==== hdl/iofo_force_mux.sv ====
`timescale 1ns/100ps

module iofo_force_mux #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] normal_value,
    input wire logic [WIDTH-1:0] override_enable,
    input wire logic [WIDTH-1:0] forced_level,
    output logic [WIDTH-1:0] effective_q
);

    logic [WIDTH-1:0] effective_d;

    // ------------------------------------------------------------------
    // Per-bit selection
    // ------------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // Clear enable passes the ordinary value; set enable forces it
        always_comb begin
            effective_d[i] = override_enable[i] ? forced_level[i]
                                                : normal_value[i];
        end
    end

    // Registered so the pin never glitches while a mask word is rewritten
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            effective_q <= '0;
        end else begin
            effective_q <= effective_d;
        end
    end

endmodule : iofo_force_mux

// ==== bench/iofo_top_properties.sv ====
`timescale 1ns/100ps
module iofo_checker
    import iofo_pkg::*;
#(
    parameter int PO_W = IOFO_PO_W,
    parameter int LI_W = IOFO_LI_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IOFO_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [PO_W-1:0] phys_out_normal,
    input wire logic [LI_W-1:0] logic_in_normal,
    input wire logic [PO_W-1:0] phys_out,
    input wire logic [LI_W-1:0] logic_in,
    input wire logic phys_trip_out,
    input wire logic phys_output_one,
    input wire logic phys_output_six,
    input wire logic forced_logic_input_first,
    input wire logic forced_logic_input_last,
    input wire logic override_active
);
    // ------------------------------------------------------------------
    // Shadow masks, rebuilt from the writes seen on the bus
    // ------------------------------------------------------------------
    logic [15:0] pen_q, pen_d, plv_q, plv_d;
    logic [31:0] len_q, len_d, llv_q, llv_d;

    function automatic logic [31:0] mrg(input logic [31:0] o);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) r[8*i +: 8] = pwdata[8*i +: 8];
        end
        return r;
    endfunction : mrg

    always_comb begin
        {pen_d, plv_d, len_d, llv_d} = {pen_q, plv_q, len_q, llv_q};
        if (psel && penable && pwrite && pready) begin
            case (paddr)
                12'h0a0: pen_d = IOFO_PO_WMASK & 16'(mrg({16'h0, pen_q}));
                12'h0a8: plv_d = 16'(mrg({16'h0, plv_q}));
                12'h0b0: len_d = mrg(len_q);
                12'h0c0: llv_d = mrg(llv_q);
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {pen_q, plv_q, len_q, llv_q} <= 96'h0;
        end else begin
            {pen_q, plv_q, len_q, llv_q} <= {pen_d, plv_d, len_d, llv_d};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Stable masks make the one-cycle output lag unambiguous
    property p_ready; pready == (psel && penable); endproperty
    a_ready: assert property (p_ready)
        else $error("pready not tied to access phase");
    property p_po_norm; $past(resetn) && $stable(pen_q) && pen_q == 16'h0
        |-> phys_out == $past(phys_out_normal); endproperty
    a_po_norm: assert property (p_po_norm)
        else $error("unforced output not following source");
    property p_po_force; $past(resetn) && $stable(pen_q) && $stable(plv_q)
        |-> (phys_out & pen_q) == (plv_q & pen_q); endproperty
    a_po_force: assert property (p_po_force)
        else $error("forced output not at forced level");
    property p_rsvd; $past(resetn)
        |-> phys_out[9:8] == $past(phys_out_normal[9:8]); endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved output bits were forced");
    property p_po_taps; phys_trip_out == phys_out[0] &&
        phys_output_one == phys_out[2] && phys_output_six == phys_out[7];
    endproperty
    a_po_taps: assert property (p_po_taps)
        else $error("output taps on wrong bits");
    property p_li_norm; $past(resetn) && $stable(len_q) && len_q == 32'h0
        |-> logic_in == $past(logic_in_normal); endproperty
    a_li_norm: assert property (p_li_norm)
        else $error("unforced input not following source");
    property p_li_force; $past(resetn) && $stable(len_q) && $stable(llv_q)
        |-> (logic_in & len_q) == (llv_q & len_q); endproperty
    a_li_force: assert property (p_li_force)
        else $error("forced input not at forced level");
    property p_li_taps; forced_logic_input_first == logic_in[0] &&
        forced_logic_input_last == logic_in[31]; endproperty
    a_li_taps: assert property (p_li_taps)
        else $error("input taps on wrong bits");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err)
        else $error("error response outside access phase");
    property p_ovr; $past(resetn)
        |-> override_active == ($past(|pen_q) || $past(|len_q));
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("override flag not matching enables");
    property p_rd_po_en; psel && penable && !pwrite && paddr == 12'h0a0
        |-> prdata == {16'h0, $past(pen_q)}; endproperty
    a_rd_po_en: assert property (p_rd_po_en)
        else $error("enable word read back wrong");
endmodule : iofo_checker

// ==== bench/iofo_top_tb_top.sv ====
`timescale 1ns/100ps
module iofo_top_tb_top;
    import iofo_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, trip, one, six, lfst, llst, ovr, er;
    logic [31:0] prdata, rd, li_n = 32'h0, li;
    logic [15:0] po_n = 16'h0, po;
    int err_total = 0;
    int checks = 0;

    iofo_top dut_u (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .phys_out_normal(po_n), .logic_in_normal(li_n), .phys_out(po),
        .logic_in(li), .phys_trip_out(trip), .phys_output_one(one),
        .phys_output_six(six), .forced_logic_input_first(lfst),
        .forced_logic_input_last(llst), .override_active(ovr));

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (4) @(posedge mclk);
    endtask : settle

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [11:0] a[4] = '{12'h0a0, 12'h0a8, 12'h0b0, 12'h0c0};
        foreach (a[i]) begin
            apb(1'b0, a[i], 32'h0);
            chk("mask after reset", 32'h0, rd);
        end
    endtask : t_reset

    task automatic t_po();
        po_n <= 16'h5a5a;
        settle();
        chk("po unforced", 32'h5a5a, {16'h0, po});
        apb(1'b1, 12'h0a0, 32'h0000_ffff);
        apb(1'b0, 12'h0a0, 32'h0);
        chk("po enable readback", 32'h0000_fcff, rd);
        apb(1'b1, 12'h0a8, 32'h0000_00a5);
        settle();
        chk("po forced", 32'h02a5, {16'h0, po});
        chk("trip one six", 32'h7, {29'h0, trip, one, six});
        chk("override flag", 32'h1, {31'h0, ovr});
        apb(1'b1, 12'h0a0, 32'h0000_0084);
        apb(1'b1, 12'h0a8, 32'h0000_0004);
        po_n <= 16'h0080;
        settle();
        chk("po partial", 32'h0004, {16'h0, po});
        chk("one six", 32'h2, {30'h0, one, six});
    endtask : t_po

    task automatic t_li();
        li_n <= 32'h8000_7ffe;
        settle();
        chk("li unforced", 32'h8000_7ffe, li);
        apb(1'b1, 12'h0b0, 32'h8000_0001);
        apb(1'b1, 12'h0c0, 32'h0000_0001);
        settle();
        chk("li forced", 32'h0000_7fff, li);
        chk("first last", 32'h2, {30'h0, lfst, llst});
        apb(1'b1, 12'h0b0, 32'h0);
        apb(1'b1, 12'h0c0, 32'hffff_ffff);
        settle();
        chk("li level ignored", 32'h8000_7ffe, li);
        apb(1'b0, 12'h0c0, 32'h0);
        chk("li level readback", 32'hffff_ffff, rd);
    endtask : t_li

    task automatic t_err();
        apb(1'b0, 12'h004, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h180, 32'h1);
        chk("status write err", 32'h1, {31'h0, er});
        apb(1'b1, 12'h0a0, 32'h0);
        settle();
        chk("po released", 32'h0080, {16'h0, po});
        chk("override clear", 32'h0, {31'h0, ovr});
    endtask : t_err

    task automatic t_stat();
        pstrb <= 4'h2;
        apb(1'b1, 12'h0a0, 32'h1234_ff56);
        pstrb <= 4'hf;
        chk("write ok", 32'h0, {31'h0, er});
        apb(1'b0, 12'h0a0, 32'h0);
        chk("lane merge", 32'h0000_fc00, rd);
        apb(1'b0, 12'h1a0, 32'h0);
        chk("summary", 32'h1, rd);
        apb(1'b0, 12'h180, 32'h0);
        chk("po status", 32'h0000_0080, rd);
        apb(1'b0, 12'h190, 32'h0);
        chk("li status", 32'h8000_7ffe, rd);
        chk("read ok", 32'h0, {31'h0, er});
    endtask : t_stat

    task automatic tally_and_finish();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_po();
        t_li();
        t_err();
        t_stat();
        tally_and_finish();
    end

    // About 100 cycles expected; cut off well beyond
    initial begin
        #(25 * 4000);
        err_total++;
        tally_and_finish();
    end
endmodule : iofo_top_tb_top

bind iofo_top iofo_checker #(.PO_W(PO_W), .LI_W(LI_W)) chk_u (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .phys_out_normal(phys_out_normal), .logic_in_normal(logic_in_normal),
    .phys_out(phys_out), .logic_in(logic_in), .phys_trip_out(phys_trip_out),
    .phys_output_one(phys_output_one), .phys_output_six(phys_output_six),
    .forced_logic_input_first(forced_logic_input_first),
    .forced_logic_input_last(forced_logic_input_last),
    .override_active(override_active));
